// file: design/thm_pkg.sv
// Constants and types for the thermal monitor sequencer.
package thm_pkg;
    localparam logic [7:0] A_RD_R1 = 8'h25;
    localparam logic [7:0] A_RD_AMB = 8'h26;
    localparam logic [7:0] A_RD_R2 = 8'h27;
    localparam logic [7:0] A_START = 8'h40;
    localparam logic [7:0] A_PRI_A = 8'h41;
    localparam logic [7:0] A_PRI_B = 8'h42;
    localparam logic [7:0] A_LIM_BASE = 8'h4E;
    localparam logic [7:0] A_SFR = 8'h7C;
    localparam logic [7:0] A_TEN_A = 8'h7E;
    localparam logic [7:0] A_CFG = 8'h7F;
    localparam logic [7:0] A_FEN = 8'h80;
    localparam logic [7:0] A_TEN_B = 8'h82;
    localparam logic [7:0] A_SEC_A = 8'hA5;
    localparam logic [7:0] A_SEC_B = 8'hA6;
    localparam logic A_PORT_INDEX = 1'b0;
    localparam int B_START = 0;
    localparam int B_LOCK = 1;
    localparam int B_MODE = 1;
    localparam int B_GLOBAL_IRQ_ENABLE = 2;
    localparam int B_GRP = 3;
    localparam int B_INIT = 7;
    localparam logic [7:0] SFR_RST = 8'h40;
    localparam logic [7:0] LIM_HI_RST = 8'h7F;
    localparam logic [7:0] LIM_LO_RST = 8'h80;
    localparam logic [7:0] FAULT_VAL = 8'h80;
    localparam logic [7:0] DIS_VAL = 8'h00;
    localparam int CLK_PERIOD_NS = 8;
    localparam int PASS_NS = 150_800_000;
    localparam int IDLE_NS = 1_000_000_000;
    localparam int SLOT_CYC = PASS_NS / (3 * CLK_PERIOD_NS);
    localparam int IDLE_CYC = IDLE_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 27;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_CONV = 3'b010,
        S_PAUSE = 3'b100
    } thm_seq_t;
endpackage

// file: design/thm_monitor.sv
// Thermal monitor sequencer with limit checks, status and interrupt.
`timescale 1ns/1ps
module thm_monitor import thm_pkg::*; #(
    parameter int SLOT_CYCLES = SLOT_CYC,
    parameter int IDLE_CYCLES = IDLE_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Host index and data port.
    input wire logic port_sel,
    input wire logic port_wr,
    input wire logic port_rd,
    input wire logic [7:0] port_wdata,
    output logic [7:0] port_rdata,
    // Converter front end.
    output logic conv_active,
    output logic [1:0] conv_channel,
    input wire logic [7:0] conv_value,
    // Asynchronous sense inputs.
    input wire logic [1:0] diode_fault,
    input wire logic [1:0] diode_nshort_gnd,
    input wire logic [2:0] fan_tach_error,
    input wire logic top_temp_status,
    // Event outputs.
    output logic monitor_irq_out_n,
    output logic monitor_combined_event,
    output logic [1:0] fan_full_on
);
    logic [7:0] sync1_q, sync2_q;
    logic [1:0] flt, nsg;
    logic [2:0] fan_err;
    logic top_s;
    logic [7:0] idx_q, start_q, sfr_q, ten_a_q, ten_b_q, fen_q;
    logic [7:0] pri_a_q, pri_b_q, sec_a_q, sec_b_q;
    logic [7:0] rd_q [3];
    logic [7:0] lo_q [3];
    logic [7:0] hi_q [3];
    logic [2:0] tcond_q;
    thm_seq_t st_q;
    logic [1:0] ch_q;
    logic [TMR_W-1:0] tmr_q;
    logic wr, init, rst_all, started, cyc_mode, upd, viol, last;
    logic [7:0] rd_new, set_a, set_b, cond_a, cond_b, drop_a, en_a;
    logic [2:0] ch_oh;
    logic [7:0] rmux;

    // Returns true when the selected channel is a remote diode.
    function automatic logic is_diode(input logic [1:0] c);
        return c != 2'd1;
    endfunction

    // Diode index of a remote channel.
    function automatic int dsel(input logic [1:0] c);
        return (c == 2'd2) ? 1 : 0;
    endfunction

    // Clears written-one bits whose cause is gone; sets win.
    function automatic logic [7:0] stat_next(input logic [7:0] cur, input logic [7:0] clr,
                                             input logic [7:0] cond, input logic [7:0] drop,
                                             input logic [7:0] set);
        return (cur & ~((clr & ~cond) | drop)) | set;
    endfunction

    // Two-stage synchroniser on every asynchronous sense input.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= {top_temp_status, fan_tach_error, diode_nshort_gnd, diode_fault};
            sync2_q <= sync1_q;
        end
    end
    assign flt = sync2_q[1:0];
    assign nsg = sync2_q[3:2];
    assign fan_err = sync2_q[6:4];
    assign top_s = sync2_q[7];

    assign wr = port_wr && (port_sel != A_PORT_INDEX);
    assign init = wr && (idx_q == A_CFG) && port_wdata[B_INIT];
    assign rst_all = !resetn || init;
    assign started = start_q[B_START];
    assign cyc_mode = sfr_q[B_MODE];
    assign ch_oh = 3'b001 << ch_q;
    assign upd = (st_q == S_CONV) && (tmr_q == '0);
    assign last = ch_q == 2'd2;

    // New reading with diode fault substitution.
    always_comb begin
        rd_new = conv_value;
        if (is_diode(ch_q) && flt[dsel(ch_q)] && !nsg[dsel(ch_q)]) begin
            rd_new = ten_a_q[ch_q] ? FAULT_VAL : DIS_VAL;
        end
    end

    // Limit check; cycle mode counts equality as a violation.
    always_comb begin
        if (cyc_mode) begin
            viol = ($signed(rd_new) >= $signed(hi_q[ch_q])) ||
                   ($signed(rd_new) <= $signed(lo_q[ch_q]));
        end else begin
            viol = ($signed(rd_new) > $signed(hi_q[ch_q])) ||
                   ($signed(rd_new) < $signed(lo_q[ch_q]));
        end
        if (is_diode(ch_q) && rd_new == FAULT_VAL) begin
            viol = 1'b1;
        end
    end

    // Host index register and start/lock control.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            idx_q <= 8'h00;
        end else if (port_wr && port_sel == A_PORT_INDEX) begin
            idx_q <= port_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            start_q <= 8'h00;
        end else if (wr && idx_q == A_START) begin
            start_q[B_LOCK] <= start_q[B_LOCK] | port_wdata[B_LOCK];
            if (!start_q[B_LOCK]) begin
                start_q[B_START] <= port_wdata[B_START];
            end
        end
    end

    // Configuration, enables and limits; frozen while running.
    always_ff @(posedge clk) begin
        if (rst_all) begin
            sfr_q <= SFR_RST;
            ten_a_q <= 8'h00;
            ten_b_q <= 8'h00;
            fen_q <= 8'h00;
            for (int i = 0; i < 3; i++) begin
                lo_q[i] <= LIM_LO_RST;
                hi_q[i] <= LIM_HI_RST;
            end
        end else if (wr && !started) begin
            if (idx_q == A_SFR) sfr_q <= port_wdata;
            if (idx_q == A_TEN_A) ten_a_q <= port_wdata;
            if (idx_q == A_TEN_B) ten_b_q <= port_wdata;
            if (idx_q == A_FEN) fen_q <= port_wdata;
            for (int i = 0; i < 3; i++) begin
                if (idx_q == A_LIM_BASE + 8'(2 * i)) lo_q[i] <= port_wdata;
                if (idx_q == A_LIM_BASE + 8'(2 * i + 1)) hi_q[i] <= port_wdata;
            end
        end
    end

    // Round-robin sequencer with slot and idle timer.
    always_ff @(posedge clk) begin
        if (rst_all || !started) begin
            st_q <= S_IDLE;
            ch_q <= 2'd0;
            tmr_q <= '0;
        end else begin
            unique case (st_q)
                S_IDLE: begin
                    st_q <= S_CONV;
                    ch_q <= 2'd0;
                    tmr_q <= TMR_W'(SLOT_CYCLES - 1);
                end
                S_CONV: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else if (!last) begin
                        ch_q <= ch_q + 2'd1;
                        tmr_q <= TMR_W'(SLOT_CYCLES - 1);
                    end else if (cyc_mode) begin
                        st_q <= S_PAUSE;
                        tmr_q <= TMR_W'(IDLE_CYCLES - 1);
                    end else begin
                        ch_q <= 2'd0;
                        tmr_q <= TMR_W'(SLOT_CYCLES - 1);
                    end
                end
                S_PAUSE: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        st_q <= S_CONV;
                        ch_q <= 2'd0;
                        tmr_q <= TMR_W'(SLOT_CYCLES - 1);
                    end
                end
            endcase
        end
    end
    assign conv_active = st_q == S_CONV;
    assign conv_channel = ch_q;

    // Readings survive soft init; one write per slot.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) rd_q[i] <= 8'h00;
            tcond_q <= 3'b000;
        end else if (upd) begin
            rd_q[ch_q] <= rd_new;
            tcond_q[ch_q] <= viol;
        end
    end

    // Status inputs shared by primary and secondary sets.
    assign en_a = {3'b000, ten_a_q[2], ten_a_q[0], ten_a_q[2:0]};
    assign set_a = {3'b000, flt & {ten_a_q[2], ten_a_q[0]} & {2{started}},
                    ch_oh & {3{upd && viol}}} & en_a;
    assign cond_a = {3'b000, flt, tcond_q};
    assign drop_a = {5'b00000, ch_oh & {3{upd}} & ~en_a[2:0]};
    assign set_b = {5'b00000, fan_err & fen_q[3:1] & {3{started}}};
    assign cond_b = {5'b00000, fan_err};

    always_ff @(posedge clk) begin
        if (rst_all) begin
            pri_a_q <= 8'h00;
            pri_b_q <= 8'h00;
            sec_a_q <= 8'h00;
            sec_b_q <= 8'h00;
        end else begin
            pri_a_q <= stat_next(pri_a_q, (wr && idx_q == A_PRI_A) ? port_wdata : 8'h00,
                                 cond_a, drop_a, set_a);
            pri_b_q <= stat_next(pri_b_q, (wr && idx_q == A_PRI_B) ? port_wdata : 8'h00,
                                 cond_b, 8'h00, set_b);
            sec_a_q <= stat_next(sec_a_q, (wr && idx_q == A_SEC_A) ? port_wdata : 8'h00,
                                 cond_a, drop_a, set_a);
            sec_b_q <= stat_next(sec_b_q, (wr && idx_q == A_SEC_B) ? port_wdata : 8'h00,
                                 cond_b, 8'h00, set_b);
        end
    end

    // Interrupt pin from primary status only; combined event also from top_temp_status.
    logic pri_evt;
    assign pri_evt = (ten_a_q[B_GRP] && |pri_a_q[2:0]) || (fen_q[0] && |pri_b_q[2:0]);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            monitor_irq_out_n <= 1'b1;
            monitor_combined_event <= 1'b0;
            fan_full_on <= 2'b00;
        end else begin
            monitor_irq_out_n <= !(sfr_q[B_GLOBAL_IRQ_ENABLE] && started && pri_evt);
            monitor_combined_event <= pri_evt || top_s;
            fan_full_on <= {rd_q[2] == FAULT_VAL, rd_q[0] == FAULT_VAL};
        end
    end

    // Register read mux.
    always_comb begin
        rmux = 8'h00;
        unique case (idx_q)
            A_RD_R1: rmux = rd_q[0];
            A_RD_AMB: rmux = rd_q[1];
            A_RD_R2: rmux = rd_q[2];
            A_START: rmux = start_q;
            A_PRI_A: rmux = pri_a_q;
            A_PRI_B: rmux = pri_b_q;
            A_SFR: rmux = sfr_q;
            A_TEN_A: rmux = ten_a_q;
            A_FEN: rmux = fen_q;
            A_TEN_B: rmux = ten_b_q;
            A_SEC_A: rmux = sec_a_q;
            A_SEC_B: rmux = sec_b_q;
            default: begin
                for (int i = 0; i < 3; i++) begin
                    if (idx_q == A_LIM_BASE + 8'(2 * i)) rmux = lo_q[i];
                    if (idx_q == A_LIM_BASE + 8'(2 * i + 1)) rmux = hi_q[i];
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            port_rdata <= 8'h00;
        end else if (port_rd) begin
            port_rdata <= (port_sel == A_PORT_INDEX) ? idx_q : rmux;
        end
    end

    // Checks.
    property p_order;
        @(posedge clk) disable iff (!resetn || init)
        upd && started && ch_q == 2'd0 |=> ch_q == 2'd1;
    endproperty
    a_order: assert property (p_order) else $error("channel order broken");

    property p_cont;
        @(posedge clk) disable iff (!resetn || init)
        upd && last && !cyc_mode && started |=> st_q == S_CONV && ch_q == 2'd0;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous loop broken");

    property p_pause;
        @(posedge clk) disable iff (!resetn || init)
        upd && last && cyc_mode && started |=> st_q == S_PAUSE && tmr_q == TMR_W'(IDLE_CYCLES - 1);
    endproperty
    a_pause: assert property (p_pause) else $error("cycle idle not entered");

    property p_set;
        @(posedge clk) disable iff (!resetn || init)
        upd && ch_q == 2'd1 && viol && ten_a_q[1] |=> pri_a_q[1] && sec_a_q[1];
    endproperty
    a_set: assert property (p_set) else $error("violation not recorded");

    property p_equal;
        @(posedge clk) disable iff (!resetn || init)
        upd && cyc_mode && ch_q == 2'd1 && rd_new == hi_q[1] && ten_a_q[1] |=> pri_a_q[1];
    endproperty
    a_equal: assert property (p_equal) else $error("equal limit not flagged");

    property p_release;
        @(posedge clk) disable iff (!resetn)
        pri_a_q[2:0] == 3'b000 && pri_b_q[2:0] == 3'b000 |=> monitor_irq_out_n;
    endproperty
    a_release: assert property (p_release) else $error("irq held without status");

    property p_noset;
        @(posedge clk) disable iff (!resetn)
        !ten_a_q[0] && !pri_a_q[0] |=> !pri_a_q[0];
    endproperty
    a_noset: assert property (p_noset) else $error("disabled event set status");

    property p_lock;
        @(posedge clk) disable iff (!resetn || init)
        wr && started && idx_q == A_TEN_A |=> $stable(ten_a_q);
    endproperty
    a_lock: assert property (p_lock) else $error("enable changed while running");

    property p_fault;
        @(posedge clk) disable iff (!resetn)
        upd && ch_q == 2'd0 && flt[0] && !nsg[0] && ten_a_q[0] |=> rd_q[0] == FAULT_VAL ##1
        fan_full_on[0];
    endproperty
    a_fault: assert property (p_fault) else $error("fault value not loaded");

    c_cycle: cover property (@(posedge clk) disable iff (!resetn) st_q == S_PAUSE);
    c_irq: cover property (@(posedge clk) disable iff (!resetn) !monitor_irq_out_n);
    c_clear: cover property (@(posedge clk) disable iff (!resetn)
        pri_a_q[1] && wr && idx_q == A_PRI_A && port_wdata[1] ##1 !pri_a_q[1]);
endmodule

// file: tb/thm_front_model.sv
// Converter and remote diode model facing the thermal monitor.
`timescale 1ns/1ps
module thm_front_model (
    // Clock.
    input wire logic clk,
    // Converter control from the monitor.
    input wire logic conv_active,
    input wire logic [1:0] conv_channel,
    // Per-channel temperatures chosen by the bench, channel 0 lowest.
    input wire logic [23:0] temps,
    // Result to the monitor.
    output logic [7:0] conv_value
);
    logic [7:0] last_q = 8'h00;
    // Outside a slot the result flips every cycle so a stale value never passes as valid.
    always_ff @(posedge clk) begin
        last_q <= conv_value;
    end
    assign conv_value = conv_active ? temps[conv_channel * 8 +: 8] : ~last_q;
endmodule

// file: tb/thm_monitor_tb_top.sv
// Self-checking bench for the thermal monitor sequencer.
`timescale 1ns/1ps
module thm_monitor_tb_top import thm_pkg::*;;
    localparam int SLOT = 20;
    localparam int IDLE = 50;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic act;
    logic [1:0] ch;
    logic [7:0] cv;
    logic [1:0] fault = 2'b00;
    logic [1:0] nsg = 2'b00;
    logic ttemp = 1'b0;
    logic irq_n;
    logic evt;
    logic [1:0] ffo;
    logic [23:0] temps = 24'h204010;
    logic cyc = 1'b0;
    logic run = 1'b0;
    logic prev_act = 1'b0;
    logic [1:0] prev_ch = 2'b00;
    int slot_cnt = 0;
    int idle_cnt = 0;
    int num_errors = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    thm_monitor #(.SLOT_CYCLES(SLOT), .IDLE_CYCLES(IDLE)) dut_u (
        .clk(clk), .resetn(resetn), .port_sel(sel), .port_wr(wr), .port_rd(rd),
        .port_wdata(wdata), .port_rdata(rdata), .conv_active(act), .conv_channel(ch),
        .conv_value(cv), .diode_fault(fault), .diode_nshort_gnd(nsg),
        .fan_tach_error(3'h0), .top_temp_status(ttemp), .monitor_irq_out_n(irq_n),
        .monitor_combined_event(evt), .fan_full_on(ffo));
    thm_front_model model_u (.clk(clk), .conv_active(act), .conv_channel(ch),
        .temps(temps), .conv_value(cv));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic set_idx(input logic [7:0] a);
        @(posedge clk);
        sel <= A_PORT_INDEX;
        wr <= 1'b1;
        wdata <= a;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        set_idx(a);
        @(posedge clk);
        sel <= ~A_PORT_INDEX;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        set_idx(a);
        @(posedge clk);
        sel <= ~A_PORT_INDEX;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check($sformatf("register %h", a), exp, rdata);
    endtask
    // Waits until the last slot of a pass ends, then lets status and pin settle.
    task automatic pass_wait();
        int n = 0;
        while (!(act === 1'b1 && ch === 2'd2) && n < 2000) begin
            @(negedge clk);
            n++;
        end
        while (act === 1'b1 && ch === 2'd2 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        check("pass completion", 8'h01, 8'(n < 2000));
    endtask
    // Watches slot order, slot length and the pause between cycle-mode passes.
    always @(negedge clk) begin
        if (act === 1'b1 && prev_act && ch !== prev_ch) begin
            check("slot length", 8'(SLOT), 8'(slot_cnt));
            check("channel order", (prev_ch == 2'd2) ? 8'h00 : 8'(prev_ch + 2'd1), 8'(ch));
            slot_cnt = 1;
        end else if (act === 1'b1) begin
            slot_cnt = prev_act ? slot_cnt + 1 : 1;
        end
        if (act !== 1'b1) begin
            idle_cnt++;
        end
        if (act === 1'b1 && !prev_act && cyc && idle_cnt > 10) begin
            check("pause length", 8'h01, 8'(idle_cnt >= IDLE && idle_cnt <= IDLE + 2));
        end
        if (act !== 1'b1 && prev_act && run && !cyc) begin
            check("continuous run", 8'h01, 8'h00);
        end
        if (act === 1'b1) begin
            idle_cnt = 0;
        end
        prev_act = (act === 1'b1);
        prev_ch = ch;
    end
    initial begin
        #(CLK_PERIOD_NS * 20000);
        num_errors++;
        $display("unexpected run time: expected done, seen hang");
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(A_PRI_A, 8'h00);
        rd_reg(A_PRI_B, 8'h00);
        rd_reg(A_SEC_A, 8'h00);
        rd_reg(A_SEC_B, 8'h00);
        rd_reg(A_SFR, SFR_RST);
        rd_reg(8'h3F, 8'h00);
        wr_reg(A_LIM_BASE + 8'h03, 8'h30);
        wr_reg(A_TEN_A, 8'h0F);
        wr_reg(A_SFR, 8'h04);
        wr_reg(A_START, 8'h01);
        run = 1'b1;
        pass_wait();
        rd_reg(A_RD_AMB, 8'h40);
        rd_reg(A_PRI_A, 8'h02);
        rd_reg(A_SEC_A, 8'h02);
        check("irq pin", 8'h00, 8'(irq_n));
        check("combined event", 8'h01, 8'(evt));
        wr_reg(A_TEN_A, 8'h00);
        rd_reg(A_TEN_A, 8'h0F);
        wr_reg(A_PRI_A, 8'h00);
        rd_reg(A_PRI_A, 8'h02);
        wr_reg(A_PRI_A, 8'h02);
        rd_reg(A_PRI_A, 8'h02);
        temps <= 24'h201010;
        pass_wait();
        pass_wait();
        wr_reg(A_PRI_A, 8'h02);
        rd_reg(A_PRI_A, 8'h00);
        check("irq pin", 8'h01, 8'(irq_n));
        rd_reg(A_SEC_A, 8'h02);
        wr_reg(A_SEC_A, 8'h02);
        rd_reg(A_SEC_A, 8'h00);
        @(posedge clk);
        ttemp <= 1'b1;
        repeat (6) @(negedge clk);
        check("combined event", 8'h01, 8'(evt));
        @(posedge clk);
        ttemp <= 1'b0;
        fault <= 2'b01;
        pass_wait();
        pass_wait();
        rd_reg(A_RD_R1, FAULT_VAL);
        rd_reg(A_PRI_A, 8'h09);
        check("fan full on", 8'h01, 8'(ffo[0]));
        check("fan full on", 8'h00, 8'(ffo[1]));
        check("irq pin", 8'h00, 8'(irq_n));
        @(posedge clk);
        nsg <= 2'b01;
        pass_wait();
        pass_wait();
        rd_reg(A_RD_R1, 8'h10);
        run = 1'b0;
        wr_reg(A_CFG, 8'h80);
        rd_reg(A_PRI_A, 8'h00);
        rd_reg(A_SFR, SFR_RST);
        @(posedge clk);
        nsg <= 2'b00;
        wr_reg(A_TEN_A, 8'h08);
        wr_reg(A_START, 8'h01);
        run = 1'b1;
        pass_wait();
        pass_wait();
        rd_reg(A_RD_R1, DIS_VAL);
        rd_reg(A_PRI_A, 8'h00);
        run = 1'b0;
        wr_reg(A_START, 8'h00);
        @(posedge clk);
        fault <= 2'b00;
        temps <= 24'h203010;
        wr_reg(A_LIM_BASE + 8'h03, 8'h30);
        wr_reg(A_TEN_A, 8'h0F);
        wr_reg(A_SFR, 8'h06);
        cyc = 1'b1;
        idle_cnt = 0;
        wr_reg(A_START, 8'h01);
        pass_wait();
        pass_wait();
        pass_wait();
        rd_reg(A_PRI_A, 8'h02);
        // Stop, drop the ambient enable, and see the bit survive until the next update.
        wr_reg(A_START, 8'h00);
        wr_reg(A_TEN_A, 8'h0D);
        rd_reg(A_PRI_A, 8'h02);
        idle_cnt = 0;
        wr_reg(A_START, 8'h01);
        pass_wait();
        rd_reg(A_PRI_A, 8'h00);
        rd_reg(A_SEC_A, 8'h00);
        check("irq pin", 8'h01, 8'(irq_n));
        conclude();
    end
endmodule
